// *** design/ubs_pkg.sv ***
// ubs_pkg: register map, field layout and reset values of the port drive and swap block
// assumes a classic wishbone slave with 32-bit data, one register per aligned word
`default_nettype none
package ubs_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          REG_W           = 8;
  localparam int          LVL_W           = 2;
  localparam int          NUM_DS          = 4;
  // register offsets (byte addresses; indices kept as printed)
  localparam logic [7:0]  UP_BOOST_IDX    = 8'hf6;
  localparam logic [7:0]  DS_BOOST_IDX    = 8'hf8;
  localparam logic [7:0]  PIN_SWAP_IDX    = 8'hfa;
  localparam logic [9:0]  UP_BOOST_ADR    = {UP_BOOST_IDX, 2'b00};
  localparam logic [9:0]  DS_BOOST_ADR    = {DS_BOOST_IDX, 2'b00};
  localparam logic [9:0]  PIN_SWAP_ADR    = {PIN_SWAP_IDX, 2'b00};
  // field positions
  localparam int          UP_LVL_LSB      = 0;
  localparam int          SWAP_UP_BIT     = 0;
  localparam int          SWAP_DS_LSB     = 1;
  // writable masks, reserved bits read zero
  localparam logic [7:0]  UP_BOOST_MASK   = 8'h03;
  localparam logic [7:0]  DS_BOOST_MASK   = 8'hff;
  localparam logic [7:0]  PIN_SWAP_MASK   = 8'h1f;
  // reset values
  localparam logic [7:0]  UP_BOOST_RST    = 8'h00;
  localparam logic [7:0]  DS_BOOST_RST    = 8'h00;
  localparam logic [7:0]  PIN_SWAP_RST    = 8'h00;
  // drive level codes
  typedef enum logic [1:0] {
    UBS_LVL_NONE = 2'h0,
    UBS_LVL_LOW  = 2'h1,
    UBS_LVL_MED  = 2'h2,
    UBS_LVL_HIGH = 2'h3
  } ubs_level_t;
endpackage : ubs_pkg
`default_nettype wire

// *** design/ubs_port_cfg.sv ***
// ubs_port_cfg: drive strength and pair swap configuration registers
// assumes classic wishbone master on clk_i; outputs feed transceivers and pin muxes
//
// Register access over Wishbone was chosen for this implementation.
`default_nettype none
module ubs_port_cfg
  import ubs_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [9:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [DATA_W-1:0]     wb_dat_i,
  output logic      [DATA_W-1:0]     wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  // transceiver drive levels
  output logic [LVL_W-1:0]           upstream_drive_level_o,
  output logic [NUM_DS*LVL_W-1:0]    ds_drive_level_o,
  // pair swap controls
  output logic                       upstream_swap_o,
  output logic [NUM_DS-1:0]          ds_swap_o
);

  // zero padding above the register byte on reads
  localparam int          RD_PAD_W = DATA_W - REG_W;

  // register images
  logic [REG_W-1:0]       up_boost_r;
  logic [REG_W-1:0]       ds_boost_r;
  logic [REG_W-1:0]       pin_swap_r;

  // request qualification
  logic                   req;
  logic                   req_wr;
  logic                   req_rd;
  logic                   lane0_en;

  // register selected by the address
  typedef enum logic [1:0] {
    UBS_SEL_NONE = 2'h0,
    UBS_SEL_UP   = 2'h1,
    UBS_SEL_DS   = 2'h3,
    UBS_SEL_SW   = 2'h2
  } ubs_regsel_t;

  ubs_regsel_t            reg_sel;
  logic                   hit_up;
  logic                   hit_ds;
  logic                   hit_sw;
  logic                   mapped;

  // write strobes and masked data
  logic                   wr_up;
  logic                   wr_ds;
  logic                   wr_sw;
  logic [REG_W-1:0]       wr_byte;
  logic [REG_W-1:0]       up_boost_nxt;
  logic [REG_W-1:0]       ds_boost_nxt;
  logic [REG_W-1:0]       pin_swap_nxt;

  // read path and bus answer
  logic [REG_W-1:0]       rd_nxt;
  logic [DATA_W-1:0]      dat_nxt;
  logic                   ack_nxt;
  logic                   err_nxt;

  // field views
  logic [LVL_W-1:0]       up_level_nxt;
  logic                   up_swap_nxt;
  logic [LVL_W-1:0]       ds_level_nxt [NUM_DS];
  logic [NUM_DS-1:0]      ds_swap_nxt;

  // one answer per request, none while ack or err stands
  always_comb begin
    req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  end

  // direction and byte lane of the taken request
  always_comb begin
    req_wr   = req && wb_we_i;
    req_rd   = req && !wb_we_i;
    lane0_en = wb_sel_i[0];
  end

  // address decode on the full byte address
  always_comb begin
    case (wb_adr_i)
      UP_BOOST_ADR: begin
        reg_sel = UBS_SEL_UP;
      end
      DS_BOOST_ADR: begin
        reg_sel = UBS_SEL_DS;
      end
      PIN_SWAP_ADR: begin
        reg_sel = UBS_SEL_SW;
      end
      default: begin
        reg_sel = UBS_SEL_NONE;
      end
    endcase
  end

  // one-hot hits from the selection
  always_comb begin
    hit_up = (reg_sel == UBS_SEL_UP);
    hit_ds = (reg_sel == UBS_SEL_DS);
    hit_sw = (reg_sel == UBS_SEL_SW);
    mapped = (reg_sel != UBS_SEL_NONE);
  end

  // writes need lane 0 and a mapped register
  always_comb begin
    wr_up = req_wr && lane0_en && hit_up;
    wr_ds = req_wr && lane0_en && hit_ds;
    wr_sw = req_wr && lane0_en && hit_sw;
  end

  // lane 0 write byte
  always_comb begin
    wr_byte = wb_dat_i[REG_W-1:0];
  end

  always_comb begin
    up_boost_nxt = wr_byte & UP_BOOST_MASK;
  end

  // downstream byte kept whole
  always_comb begin
    ds_boost_nxt = wr_byte & DS_BOOST_MASK;
  end

  always_comb begin
    pin_swap_nxt = wr_byte & PIN_SWAP_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_boost_r <= UP_BOOST_RST;
    end else if (wr_up) begin
      up_boost_r <= up_boost_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ds_boost_r <= DS_BOOST_RST;
    end else if (wr_ds) begin
      ds_boost_r <= ds_boost_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_swap_r <= PIN_SWAP_RST;
    end else if (wr_sw) begin
      pin_swap_r <= pin_swap_nxt;
    end
  end

  always_comb begin
    rd_nxt = '0;
    case (reg_sel)
      UBS_SEL_UP: begin
        rd_nxt = up_boost_r;
      end
      UBS_SEL_DS: begin
        rd_nxt = ds_boost_r;
      end
      UBS_SEL_SW: begin
        rd_nxt = pin_swap_r;
      end
      default: begin
        rd_nxt = '0;
      end
    endcase
  end

  // ack for a mapped register
  always_comb begin
    ack_nxt = req && mapped;
  end

  // err for an unmapped address
  always_comb begin
    err_nxt = req && !mapped;
  end

  // read data beside ack, zero otherwise
  always_comb begin
    dat_nxt = '0;
    if (req_rd && mapped) begin
      dat_nxt = {{RD_PAD_W{1'b0}}, rd_nxt};
    end
  end

  // ack stands one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= ack_nxt;
    end
  end

  // err stands one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= err_nxt;
    end
  end

  // read data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else begin
      wb_dat_o <= dat_nxt;
    end
  end

  always_comb begin
    up_level_nxt = up_boost_r[UP_LVL_LSB +: LVL_W];
  end

  always_comb begin
    up_swap_nxt = pin_swap_r[SWAP_UP_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upstream_drive_level_o <= UBS_LVL_NONE;
    end else begin
      upstream_drive_level_o <= up_level_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upstream_swap_o <= 1'b0;
    end else begin
      upstream_swap_o <= up_swap_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_DS; g++) begin : g_port
      always_comb begin
        ds_level_nxt[g] = ds_boost_r[g*LVL_W +: LVL_W];
        ds_swap_nxt[g]  = pin_swap_r[SWAP_DS_LSB + g];
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ds_drive_level_o[g*LVL_W +: LVL_W] <= UBS_LVL_NONE;
        end else begin
          ds_drive_level_o[g*LVL_W +: LVL_W] <= ds_level_nxt[g];
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ds_swap_o[g] <= 1'b0;
        end else begin
          ds_swap_o[g] <= ds_swap_nxt[g];
        end
      end
    end
  endgenerate

endmodule : ubs_port_cfg
`default_nettype wire

// *** verification/testbench.sv ***
// testbench: drives ubs_port_cfg through the wishbone host model
// assumes 40 MHz clock, synchronous reset
`default_nettype none
module testbench import ubs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, we, ack, err, usw;
  logic [9:0]  adr;
  logic [3:0]  sel, dsw;
  logic [31:0] wdat, rdat;
  logic [1:0]  ulv;
  logic [7:0]  dlv;
  int          mismatches = 0;
  int          n_compared = 0;
  always #12.5 clk_i = ~clk_i;
  ubs_port_cfg ubs_port_cfg_inst (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .upstream_drive_level_o(ulv), .ds_drive_level_o(dlv), .upstream_swap_o(usw), .ds_swap_o(dsw));
  ubs_wb_host host (.clk_i, .ack_i(ack), .err_i(err), .cyc_o(cyc), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic t_levels;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      host.xfer(1'b1, UP_BOOST_ADR, {6'h3f, c}, 4'h1);
      host.xfer(1'b1, DS_BOOST_ADR, {c, c + 2'h1, c + 2'h2, c + 2'h3}, 4'h1);
      @(negedge clk_i);
      chk(ulv, c);
      chk(dlv, {c, c + 2'h1, c + 2'h2, c + 2'h3});
      host.xfer(1'b0, UP_BOOST_ADR, 8'h00, 4'h1);
      chk(rdat, c);
    end
    host.xfer(1'b1, UP_BOOST_ADR, 8'h00, 4'h1);
    host.xfer(1'b1, DS_BOOST_ADR, 8'h00, 4'h1);
    @(negedge clk_i);
    chk({ulv, dlv}, 32'h0);
  endtask : t_levels
  task automatic t_reset;
    host.xfer(1'b1, PIN_SWAP_ADR, 8'h1f, 4'h1);
    host.xfer(1'b1, DS_BOOST_ADR, 8'hff, 4'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({ulv, dlv, usw, dsw}, 32'h0);
    host.xfer(1'b0, DS_BOOST_ADR, 8'h00, 4'h1);
    chk(rdat, 32'h0);
  endtask : t_reset
  task automatic t_swap;
    host.xfer(1'b1, PIN_SWAP_ADR, 8'hf5, 4'h1);
    host.xfer(1'b1, PIN_SWAP_ADR, 8'h0a, 4'h0);
    host.xfer(1'b0, PIN_SWAP_ADR, 8'h00, 4'h1);
    chk(rdat, 32'h15);
    chk({dsw, usw}, 32'h15);
    host.xfer(1'b1, PIN_SWAP_ADR, 8'h0a, 4'h1);
    host.xfer(1'b1, 10'h000, 8'hff, 4'h1);
    chk(err, 32'h1);
    @(negedge clk_i);
    chk({dsw, usw}, 32'h0a);
  endtask : t_swap
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({ulv, dlv, usw, dsw}, 32'h0);
    t_levels();
    t_swap();
    t_reset();
    give_verdict();
  end
  initial begin
    #20us;
    mismatches++;
    give_verdict();
  end
endmodule : testbench
bind ubs_port_cfg ubs_props props_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .upstream_drive_level_o(upstream_drive_level_o),
  .ds_drive_level_o(ds_drive_level_o), .upstream_swap_o(upstream_swap_o), .ds_swap_o(ds_swap_o));
`default_nettype wire

// *** verification/ubs_props.sv ***
// ubs_props: port checks of the drive and swap block
// assumes a bind onto ubs_port_cfg
`default_nettype none
module ubs_props
  import ubs_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_we_i,
  input wire logic [9:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic              wb_ack_o,
  input wire logic [1:0]        upstream_drive_level_o,
  input wire logic [7:0]        ds_drive_level_o,
  input wire logic              upstream_swap_o,
  input wire logic [3:0]        ds_swap_o
);
  logic [7:0] d;
  logic       wr, wu, wd, ws;
  assign d  = wb_dat_i[7:0];
  assign wr = wb_ack_o & wb_we_i & wb_sel_i[0];
  assign wu = wr & (wb_adr_i == UP_BOOST_ADR);
  assign wd = wr & (wb_adr_i == DS_BOOST_ADR);
  assign ws = wr & (wb_adr_i == PIN_SWAP_ADR);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_UP: assert property (wu |=> upstream_drive_level_o == $past(d[1:0])) else $error("up level");
  AST_DS4: assert property (wd |=> ds_drive_level_o[7:6] == $past(d[7:6])) else $error("ds4 level");
  AST_DS3: assert property (wd |=> ds_drive_level_o[5:4] == $past(d[5:4])) else $error("ds3 level");
  AST_DS2: assert property (wd |=> ds_drive_level_o[3:2] == $past(d[3:2])) else $error("ds2 level");
  AST_DS1: assert property (wd |=> ds_drive_level_o[1:0] == $past(d[1:0])) else $error("ds1 level");
  AST_SWU: assert property (ws |=> upstream_swap_o == $past(d[0])) else $error("up swap");
  AST_SWD: assert property (ws |=> ds_swap_o == $past(d[4:1])) else $error("ds swap");
  AST_ACK: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule : ubs_props
`default_nettype wire

// *** verification/ubs_wb_host.sv ***
// ubs_wb_host: classic wishbone master standing for the loader
// assumes calls only after reset is released
`default_nettype none
module ubs_wb_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  output logic             cyc_o,
  output logic             we_o,
  output logic [9:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {cyc_o, we_o, adr_o, sel_o, dat_o} = '0;
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] v, input logic [3:0] s);
    @(posedge clk_i);
    {cyc_o, we_o, adr_o, sel_o, dat_o} <= {1'b1, w, a, s, 24'h0, v};
    do @(posedge clk_i); while (!(ack_i | err_i));
    {cyc_o, adr_o, dat_o} <= {1'b0, ~adr_o, ~dat_o};
  endtask : xfer
endmodule : ubs_wb_host
`default_nettype wire
